// file: hdl/motor_command_input_frontend.sv
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module motor_command_input_frontend #(
   parameter int PWM_STANDBY_CYC  = cmd_frontend_pkg::PWM_STANDBY_CYC,
   parameter int FREQ_STANDBY_CYC = cmd_frontend_pkg::FREQ_STANDBY_CYC,
   parameter int MEAS_WINDOW_CYC  = cmd_frontend_pkg::MEAS_WINDOW_CYC,
   parameter int CAL_WINDOW_CYC   = cmd_frontend_pkg::CAL_WINDOW_CYC
) (
   input  logic        clk_sys,
   input  logic        rst,
   input  logic        wb_cyc_i,
   input  logic        wb_stb_i,
   input  logic        wb_we_i,
   input  logic [7:0]  wb_adr_i,
   input  logic [3:0]  wb_sel_i,
   input  logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic        wb_ack_o,
   input  logic        brake_in,
   input  logic        direction_in,
   input  logic        driver_kill_in,
   input  logic        command_wake_in,
   input  logic        reference_clock_in,
   input  logic [7:0]  analog_level,
   input  logic [7:0]  output_speed,
   output logic        brake_active,
   output logic        gates_pulldown,
   output logic        restart_pulse,
   output logic        sleep_request,
   output logic        direction_reverse,
   output logic [2:0]  phase_order,
   output logic [1:0]  monitor_pin_mode,
   output logic        monitor_pin_oe,
   output logic [7:0]  duty_command,
   output logic [7:0]  reference_out,
   output logic [23:0] scaled_reference,
   output logic [1:0]  regulation_mode,
   output logic        motor_stop,
   output logic [15:0] osc_trim
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [4:0] syncA_reg;
   logic [4:0] syncB_reg;
   logic [4:0] pinsIn;
   assign pinsIn = {reference_clock_in, command_wake_in, driver_kill_in, direction_in, brake_in};
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         syncA_reg <= 5'h00;
         syncB_reg <= 5'h00;
      end else begin
         syncA_reg <= pinsIn;
         syncB_reg <= syncA_reg;
      end
   end
   logic brakePin, dirPin, killPin, cmdPin, refClk;
   assign {refClk, cmdPin, killPin, dirPin, brakePin} = syncB_reg;

   // ************************************************************
   // registers and wishbone slave
   // ************************************************************
   logic [31:0] config_reg, serial_reg, thresh_reg, limit_reg, profile_reg, timeout_reg;
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic        access;
   logic        wrEn;
   assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wrEn   = access & wb_we_i;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         config_reg  <= cmd_frontend_pkg::CONFIG_RST;
         serial_reg  <= 32'h0000_0000;
         thresh_reg  <= 32'h0000_0000;
         limit_reg   <= 32'h0000_0000;
         profile_reg <= 32'h0000_0000;
         timeout_reg <= 32'h0000_0000;
      end else if (wrEn) begin
         case (wb_adr_i)
            cmd_frontend_pkg::CONFIG_OFF:  config_reg  <= merge(config_reg, wb_dat_i, wb_sel_i);
            cmd_frontend_pkg::SERIAL_OFF:  serial_reg  <= merge(serial_reg, wb_dat_i, wb_sel_i);
            cmd_frontend_pkg::THRESH_OFF:  thresh_reg  <= merge(thresh_reg, wb_dat_i, wb_sel_i);
            cmd_frontend_pkg::LIMIT_OFF:   limit_reg   <= merge(limit_reg, wb_dat_i, wb_sel_i);
            cmd_frontend_pkg::PROFILE_OFF: profile_reg <= merge(profile_reg, wb_dat_i, wb_sel_i);
            cmd_frontend_pkg::TIMEOUT_OFF: timeout_reg <= merge(timeout_reg, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // config fields
   logic [1:0] srcSel, profSel, pinFn;
   assign srcSel  = config_reg[cmd_frontend_pkg::SRC_LSB +: 2];
   assign profSel = config_reg[cmd_frontend_pkg::PROF_LSB +: 2];
   assign pinFn   = config_reg[cmd_frontend_pkg::PINFN_LSB +: 2];
   // thresholds: [7:0] analog standby, [15:8] analog full scale, [23:16] brake speed threshold
   logic [7:0] anaStandby, anaFull, brakeThresh;
   assign anaStandby  = thresh_reg[7:0];
   assign anaFull     = thresh_reg[15:8];
   assign brakeThresh = thresh_reg[23:16];
   // limits: [15:0] max speed or power, [31:16] max input frequency in edges per window
   logic [15:0] maxScale, maxFreq;
   assign maxScale = limit_reg[15:0];
   assign maxFreq  = limit_reg[31:16];

   // ************************************************************
   // brake, direction, kill
   // ************************************************************
   typedef enum logic [2:0] {
      BRK_RUN  = 3'b001,
      BRK_SLOW = 3'b010,
      BRK_HOLD = 3'b100
   } brake_state_t;
   brake_state_t brkState_reg, brkState_next;
   logic brakeWant;
   assign brakeWant = config_reg[cmd_frontend_pkg::BRK_OVEN_BIT] ?
                      config_reg[cmd_frontend_pkg::BRK_OVVAL_BIT] : brakePin;
   always_comb begin
      brkState_next = brkState_reg;
      case (brkState_reg)
         BRK_RUN:  if (brakeWant) brkState_next = BRK_SLOW;
         BRK_SLOW: if (!brakeWant) brkState_next = BRK_RUN;
                   else if (output_speed <= brakeThresh) brkState_next = BRK_HOLD;
         BRK_HOLD: if (!brakeWant) brkState_next = BRK_RUN;
         default:  brkState_next = BRK_RUN;
      endcase
   end

   logic dirSel;
   logic fwrevReverse;
   assign dirSel = (profSel == cmd_frontend_pkg::PROF_FWREV) ? fwrevReverse :
                   (config_reg[cmd_frontend_pkg::DIR_OVEN_BIT] ?
                    config_reg[cmd_frontend_pkg::DIR_OVVAL_BIT] : dirPin);
   logic killPrev_reg;

   // ************************************************************
   // pwm duty and frequency measurement
   // ************************************************************
   logic        cmdPrev_reg;
   logic [31:0] winCnt_reg, highCnt_reg, edgeCnt_reg, lowCnt_reg;
   logic [7:0]  pwmDuty_reg, freqDuty_reg;
   logic        winEnd, riseEdge;
   logic [39:0] dutyProd;
   logic [39:0] freqProd;
   assign winEnd   = (winCnt_reg == 32'(MEAS_WINDOW_CYC - 1));
   assign riseEdge = cmdPin & ~cmdPrev_reg;
   // the closing cycle of a window counts too, else a steady high reads short of full
   assign dutyProd = ({8'h00, highCnt_reg} + {39'h0, cmdPin}) * 40'(255);
   assign freqProd = ({8'h00, edgeCnt_reg} + {39'h0, riseEdge}) * 40'(255);
   logic [31:0] freqScaled;
   assign freqScaled = (maxFreq == 16'h0000) ? 32'h0000_0000 : 32'(freqProd / {24'h0, maxFreq});
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmdPrev_reg  <= 1'b0;
         winCnt_reg   <= 32'h0;
         highCnt_reg  <= 32'h0;
         edgeCnt_reg  <= 32'h0;
         lowCnt_reg   <= 32'h0;
         pwmDuty_reg  <= 8'h00;
         freqDuty_reg <= 8'h00;
      end else begin
         cmdPrev_reg <= cmdPin;
         lowCnt_reg  <= cmdPin ? 32'h0 : ((lowCnt_reg == 32'hffff_ffff) ? lowCnt_reg : lowCnt_reg + 32'h1);
         if (winEnd) begin
            winCnt_reg   <= 32'h0;
            highCnt_reg  <= 32'h0;
            edgeCnt_reg  <= 32'h0;
            pwmDuty_reg  <= 8'(dutyProd / 40'(MEAS_WINDOW_CYC));
            freqDuty_reg <= (freqScaled > 32'h0000_00ff) ? cmd_frontend_pkg::FULL_DUTY : freqScaled[7:0];
         end else begin
            winCnt_reg  <= winCnt_reg + 32'h1;
            highCnt_reg <= highCnt_reg + {31'h0, cmdPin};
            edgeCnt_reg <= edgeCnt_reg + {31'h0, riseEdge};
         end
      end
   end
   logic pwmIdle, freqIdle;
   assign pwmIdle  = (lowCnt_reg >= 32'(PWM_STANDBY_CYC));
   assign freqIdle = (lowCnt_reg >= 32'(FREQ_STANDBY_CYC));

   // ************************************************************
   // demand selection
   // ************************************************************
   logic [7:0] anaDuty;
   logic [15:0] anaProd;
   logic [7:0] anaSpan;
   assign anaSpan = anaFull - anaStandby;
   assign anaProd = 16'(analog_level - anaStandby) * 16'(255);
   assign anaDuty = (analog_level < anaStandby) ? 8'h00 :
                    (analog_level >= anaFull || anaSpan == 8'h00) ? cmd_frontend_pkg::FULL_DUTY :
                    8'(anaProd / {8'h00, anaSpan});
   logic [7:0] demand;
   always_comb begin
      case (srcSel)
         cmd_frontend_pkg::SRC_ANALOG: demand = anaDuty;
         cmd_frontend_pkg::SRC_PWM:    demand = pwmIdle ? 8'h00 : pwmDuty_reg;
         cmd_frontend_pkg::SRC_FREQ:   demand = freqIdle ? 8'h00 : freqDuty_reg;
         cmd_frontend_pkg::SRC_SERIAL: demand = serial_reg[7:0];
         default:                      demand = 8'h00;
      endcase
   end

   // ************************************************************
   // profiler: breakpoints [7:0] knee low, [15:8] knee high,
   // [23:16] reference at low knee, [31:24] reference at high knee
   // ************************************************************
   logic [7:0] kneeLo, kneeHi, refLo, refHi;
   assign {refHi, refLo, kneeHi, kneeLo} = profile_reg;
   logic [7:0] kneeMid;
   assign kneeMid = 8'(({1'b0, kneeLo} + {1'b0, kneeHi}) >> 1);
   logic [15:0] linProd;
   logic [7:0]  linSpan;
   assign linSpan = kneeHi - kneeLo;
   assign linProd = 16'(demand - kneeLo) * 16'(refHi - refLo);
   logic [7:0] linRef, stairRef, fwrevRef;
   assign linRef = (demand <= kneeLo) ? refLo : (demand >= kneeHi || linSpan == 8'h00) ? refHi :
                   8'(refLo + 8'(linProd / {8'h00, linSpan}));
   assign stairRef = (demand < kneeMid) ? refLo : refHi;
   assign fwrevReverse = (demand >= kneeMid);
   assign fwrevRef = fwrevReverse ? refHi : refLo;
   logic [7:0] refX;
   always_comb begin
      case (profSel)
         cmd_frontend_pkg::PROF_NONE:  refX = demand;
         cmd_frontend_pkg::PROF_LIN:   refX = linRef;
         cmd_frontend_pkg::PROF_STAIR: refX = stairRef;
         cmd_frontend_pkg::PROF_FWREV: refX = fwrevRef;
         default:                      refX = demand;
      endcase
      if (demand == 8'h00) refX = 8'h00;
   end
   logic [23:0] scaledNext;
   assign scaledNext = 24'((24'(refX) * 24'(maxScale)) / 24'(255));
   logic [1:0] regMode;
   assign regMode = !config_reg[cmd_frontend_pkg::CLOSED_BIT] ? 2'h2 :
                    (config_reg[cmd_frontend_pkg::CPOWER_BIT] ? 2'h1 : 2'h0);

   // ************************************************************
   // oscillator calibration against reference clock
   // ************************************************************
   logic        refPrev_reg;
   logic [15:0] calCnt_reg, refEdges_reg;
   logic [15:0] refTotal;
   // an edge in the closing cycle belongs to this window, not the next
   assign refTotal = refEdges_reg + {15'h0, refClk & ~refPrev_reg};
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         refPrev_reg  <= 1'b0;
         calCnt_reg   <= 16'h0;
         refEdges_reg <= 16'h0;
         osc_trim     <= 16'h0;
      end else begin
         refPrev_reg <= refClk;
         if (calCnt_reg == 16'(CAL_WINDOW_CYC - 1)) begin
            calCnt_reg   <= 16'h0;
            refEdges_reg <= 16'h0;
            // no reference: keep the last trim rather than collapse it
            if (refTotal != 16'h0) osc_trim <= refTotal;
         end else begin
            calCnt_reg   <= calCnt_reg + 16'h1;
            refEdges_reg <= refTotal;
         end
      end
   end

   // ************************************************************
   // output registers
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         brkState_reg      <= BRK_RUN;
         killPrev_reg      <= 1'b0;
         brake_active      <= 1'b0;
         gates_pulldown    <= 1'b0;
         restart_pulse     <= 1'b0;
         sleep_request     <= 1'b0;
         direction_reverse <= 1'b0;
         phase_order       <= 3'h0;
         monitor_pin_mode  <= cmd_frontend_pkg::PIN_MONITOR;
         monitor_pin_oe    <= 1'b1;
         duty_command      <= 8'h00;
         reference_out     <= 8'h00;
         scaled_reference  <= 24'h0;
         regulation_mode   <= 2'h0;
         motor_stop        <= 1'b1;
      end else begin
         brkState_reg      <= brkState_next;
         killPrev_reg      <= killPin;
         brake_active      <= (brkState_next == BRK_HOLD);
         gates_pulldown    <= killPin;
         restart_pulse     <= killPrev_reg & ~killPin;
         // sleep follows the command pin unless the source is analog and the pin role is not analog; never the kill pin
         sleep_request     <= ~cmdPin & ((pinFn == cmd_frontend_pkg::PIN_ANALOG) |
                              (srcSel != cmd_frontend_pkg::SRC_ANALOG));
         direction_reverse <= dirSel;
         // code 1 is the a, c, b sequence, code 0 the a, b, c sequence
         phase_order       <= dirSel ? 3'h1 : 3'h0;
         monitor_pin_mode  <= pinFn;
         monitor_pin_oe    <= (pinFn != cmd_frontend_pkg::PIN_ANALOG);
         duty_command      <= demand;
         reference_out     <= refX;
         scaled_reference  <= scaledNext;
         regulation_mode   <= regMode;
         motor_stop        <= (refX == 8'h00) | killPin | (brkState_next == BRK_HOLD);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0;
      end else begin
         ack_reg <= access;
         case (wb_adr_i)
            cmd_frontend_pkg::CONFIG_OFF:  rdat_reg <= config_reg;
            cmd_frontend_pkg::SERIAL_OFF:  rdat_reg <= serial_reg;
            cmd_frontend_pkg::THRESH_OFF:  rdat_reg <= thresh_reg;
            cmd_frontend_pkg::LIMIT_OFF:   rdat_reg <= limit_reg;
            cmd_frontend_pkg::PROFILE_OFF: rdat_reg <= profile_reg;
            cmd_frontend_pkg::TIMEOUT_OFF: rdat_reg <= timeout_reg;
            cmd_frontend_pkg::STATUS_OFF:  rdat_reg <= {16'h0, osc_trim[7:0], 1'b0, motor_stop,
                                                        brake_active, gates_pulldown, dirSel,
                                                        sleep_request, brkState_reg[1], 1'b0};
            cmd_frontend_pkg::REFOUT_OFF:  rdat_reg <= {scaled_reference[15:0], reference_out, duty_command};
            default:                       rdat_reg <= 32'h0;
         endcase
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
endmodule

// file: hdl/cmd_frontend_pkg.sv
package cmd_frontend_pkg;
   // ************************************************************
   // register map (word aligned byte addresses)
   // ************************************************************
   localparam logic [7:0] CONFIG_OFF   = 8'h00;
   localparam logic [7:0] SERIAL_OFF   = 8'h04;
   localparam logic [7:0] THRESH_OFF   = 8'h08;
   localparam logic [7:0] LIMIT_OFF    = 8'h0c;
   localparam logic [7:0] PROFILE_OFF  = 8'h10;
   localparam logic [7:0] STATUS_OFF   = 8'h14;
   localparam logic [7:0] REFOUT_OFF   = 8'h18;
   localparam logic [7:0] TIMEOUT_OFF  = 8'h1c;
   // ************************************************************
   // config fields
   // ************************************************************
   localparam int SRC_LSB       = 0;
   localparam int PROF_LSB      = 2;
   localparam int PINFN_LSB     = 4;
   localparam int BRK_OVEN_BIT  = 6;
   localparam int BRK_OVVAL_BIT = 7;
   localparam int DIR_OVEN_BIT  = 8;
   localparam int DIR_OVVAL_BIT = 9;
   localparam int CLOSED_BIT    = 10;
   localparam int CPOWER_BIT    = 11;
   localparam logic [1:0] SRC_ANALOG = 2'h0;
   localparam logic [1:0] SRC_PWM    = 2'h1;
   localparam logic [1:0] SRC_SERIAL = 2'h2;
   localparam logic [1:0] SRC_FREQ   = 2'h3;
   localparam logic [1:0] PROF_NONE  = 2'h0;
   localparam logic [1:0] PROF_LIN   = 2'h1;
   localparam logic [1:0] PROF_STAIR = 2'h2;
   localparam logic [1:0] PROF_FWREV = 2'h3;
   localparam logic [1:0] PIN_MONITOR = 2'h0;
   localparam logic [1:0] PIN_CSA     = 2'h1;
   localparam logic [1:0] PIN_ANALOG  = 2'h2;
   localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
   localparam logic [7:0]  FULL_DUTY  = 8'hff;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_MHZ           = 200;
   localparam int PWM_STANDBY_US    = 20000;
   localparam int FREQ_STANDBY_US   = 20000;
   localparam int PWM_STANDBY_CYC   = PWM_STANDBY_US * CLK_MHZ;
   localparam int FREQ_STANDBY_CYC  = FREQ_STANDBY_US * CLK_MHZ;
   localparam int MEAS_WINDOW_CYC   = 2000000;
   localparam int CAL_WINDOW_CYC    = 4096;
endpackage

// file: test/motor_command_input_frontend_properties.sv
`timescale 1ns/10ps
module motor_command_input_frontend_props (
   input logic        clk_sys,
   input logic        rst,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_ack_o,
   input logic        driver_kill_in,
   input logic        gates_pulldown,
   input logic        restart_pulse,
   input logic        brake_active,
   input logic        direction_reverse,
   input logic [2:0]  phase_order,
   input logic [1:0]  monitor_pin_mode,
   input logic        monitor_pin_oe,
   input logic [7:0]  duty_command,
   input logic [7:0]  reference_out,
   input logic [23:0] scaled_reference,
   input logic        motor_stop
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ************************************************************
   // pin and reference relations
   // ************************************************************
   a_kill_gates_off: assert property (gates_pulldown == $past(driver_kill_in, 3))
      else $error("gate pulldown does not follow kill pin");
   a_restart_after_kill: assert property ($fell(gates_pulldown) |-> ##[0:2] restart_pulse)
      else $error("no restart after kill release");
   a_restart_one_cycle: assert property (restart_pulse |=> !restart_pulse)
      else $error("restart pulse longer than one cycle");
   a_oe_by_mode: assert property (monitor_pin_oe == (monitor_pin_mode != cmd_frontend_pkg::PIN_ANALOG))
      else $error("monitor pin enable disagrees with its role");
   a_zero_demand_stops: assert property ((duty_command == 8'h00) [*3] |-> motor_stop)
      else $error("zero demand without stop");
   a_phase_by_dir: assert property ($stable(direction_reverse) |-> ((phase_order != 3'h0) == direction_reverse))
      else $error("phase order disagrees with direction");
   a_scale_of_zero: assert property ((reference_out == 8'h00) [*3] |-> scaled_reference == 24'h0)
      else $error("zero reference scaled to nonzero");
   a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   cover property (brake_active);
   cover property (restart_pulse);
   cover property (duty_command == 8'hff);
endmodule

// file: test/command_host_model.sv
`timescale 1ns/10ps
module command_host_model (
   input  logic clk_sys,
   input  logic brakeReq,
   input  logic dirReq,
   input  logic killReq,
   input  logic wakeReq,
   input  logic wakeToggle,
   output logic brake_in,
   output logic direction_in,
   output logic driver_kill_in,
   output logic command_wake_in,
   output logic reference_clock_in
);
   // ************************************************************
   // host pins, changed by nonblocking assignment on the edge, in the same time step as it
   // ************************************************************
   logic [1:0] refDiv;
   initial begin
      {brake_in, direction_in, driver_kill_in, command_wake_in, reference_clock_in} = 5'h00;
      refDiv = 2'h0;
   end
   always @(posedge clk_sys) begin
      brake_in <= brakeReq;
      direction_in <= dirReq;
      driver_kill_in <= killReq;
      // toggling every cycle is far above any sane maximum frequency
      command_wake_in <= wakeToggle ? !command_wake_in : wakeReq;
      refDiv <= refDiv + 2'h1;
      if (refDiv == 2'h2) begin
         reference_clock_in <= !reference_clock_in;
      end
   end
endmodule

// file: test/motor_command_input_frontend_test.sv
`timescale 1ns/10ps
`define CHECK_EQ(g, e) checkVal(32'(g), 32'(e))
module motor_command_input_frontend_test;
   logic        clk_sys, rst, wbCyc, wbStb, wbWe, wbAck, seen;
   logic [7:0]  wbAdr, analogLevel, outputSpeed, dutyCommand, referenceOut;
   logic [31:0] wbDatI, wbDatO, rd;
   logic [3:0]  wbSel;
   logic        brakeIn, dirIn, killIn, wakeIn, refClkIn, brakeReq, dirReq, killReq, wakeReq, wakeToggle;
   logic        brakeActive, gatesPulldown, restartPulse, sleepRequest, dirReverse, monOe, motorStop;
   logic [2:0]  phaseOrder;
   logic [1:0]  monMode, regMode;
   logic [23:0] scaledRef;
   logic [15:0] oscTrim;
   int          badCount, samplesChecked;
   logic [31:0] cfgTab [3] = '{32'h0002, 32'h0c02, 32'h0402};
   logic [1:0]  modeTab [3] = '{2'h2, 2'h1, 2'h0};
   command_host_model u_command_host_model (.clk_sys(clk_sys), .brakeReq(brakeReq), .dirReq(dirReq),
      .killReq(killReq), .wakeReq(wakeReq), .wakeToggle(wakeToggle), .brake_in(brakeIn),
      .direction_in(dirIn), .driver_kill_in(killIn), .command_wake_in(wakeIn), .reference_clock_in(refClkIn));
   motor_command_input_frontend #(.PWM_STANDBY_CYC(50), .FREQ_STANDBY_CYC(50), .MEAS_WINDOW_CYC(100),
      .CAL_WINDOW_CYC(64)) u_motor_command_input_frontend (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .brake_in(brakeIn), .direction_in(dirIn),
      .driver_kill_in(killIn), .command_wake_in(wakeIn), .reference_clock_in(refClkIn),
      .analog_level(analogLevel), .output_speed(outputSpeed), .brake_active(brakeActive),
      .gates_pulldown(gatesPulldown), .restart_pulse(restartPulse), .sleep_request(sleepRequest),
      .direction_reverse(dirReverse), .phase_order(phaseOrder), .monitor_pin_mode(monMode),
      .monitor_pin_oe(monOe), .duty_command(dutyCommand), .reference_out(referenceOut),
      .scaled_reference(scaledRef), .regulation_mode(regMode), .motor_stop(motorStop), .osc_trim(oscTrim));
   // ************************************************************
   // bus cycles and comparisons
   // ************************************************************
   task automatic printVerdict();
      $display("checked %0d, mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         badCount++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wbAccess(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= d;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      if (n >= 20) begin
         badCount++;
         $display("unexpected at %0t: bus timeout", $time);
         printVerdict();
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      {rst, wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} = {1'b1, 11'h0, 32'h0, 4'hf};
      {brakeReq, dirReq, killReq, wakeReq, wakeToggle, analogLevel, outputSpeed} = 21'h0;
      {badCount, samplesChecked} = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      waitc(0);
      `CHECK_EQ(motorStop, 1'b1);
      `CHECK_EQ(monOe, 1'b1);
      wbAccess(1'b0, cmd_frontend_pkg::CONFIG_OFF, 32'h0);
      `CHECK_EQ(rd, cmd_frontend_pkg::CONFIG_RST);
      wbAccess(1'b1, 8'h20, 32'hffff_ffff);
      wbAccess(1'b0, 8'h20, 32'h0);
      `CHECK_EQ(rd, 32'h0);
      $display("test reset done");
      wbAccess(1'b1, cmd_frontend_pkg::LIMIT_OFF, 32'h0010_01fe);
      wbAccess(1'b1, cmd_frontend_pkg::SERIAL_OFF, 32'h80);
      for (int i = 0; i < 3; i++) begin
         wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, cfgTab[i]);
         waitc(6);
         `CHECK_EQ(regMode, modeTab[i]);
         `CHECK_EQ(dutyCommand, 8'h80);
         `CHECK_EQ(referenceOut, 8'h80);
         if (i > 0) `CHECK_EQ(scaledRef, 24'h000100);
      end
      wbAccess(1'b0, cmd_frontend_pkg::CONFIG_OFF, 32'h0);
      `CHECK_EQ(rd, 32'h0402);
      wbAccess(1'b1, cmd_frontend_pkg::SERIAL_OFF, 32'h0);
      waitc(6);
      `CHECK_EQ(motorStop, 1'b1);
      $display("test serial done");
      @(posedge clk_sys);
      dirReq <= 1'b1;
      waitc(6);
      `CHECK_EQ(dirReverse, 1'b1);
      `CHECK_EQ(phaseOrder != 3'h0, 1'b1);
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0502);
      waitc(6);
      `CHECK_EQ(phaseOrder, 3'h0);
      dirReq <= 1'b0;
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0702);
      waitc(6);
      `CHECK_EQ(dirReverse, 1'b1);
      $display("test direction done");
      wbAccess(1'b1, cmd_frontend_pkg::THRESH_OFF, 32'h0020_c020);
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0402);
      wbAccess(1'b1, cmd_frontend_pkg::SERIAL_OFF, 32'h80);
      outputSpeed <= 8'h40;
      brakeReq <= 1'b1;
      waitc(8);
      `CHECK_EQ(brakeActive, 1'b0);
      @(posedge clk_sys);
      outputSpeed <= 8'h10;
      waitc(60);
      `CHECK_EQ(brakeActive, 1'b1);
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0442);
      waitc(6);
      `CHECK_EQ(brakeActive, 1'b0);
      brakeReq <= 1'b0;
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h04c2);
      waitc(8);
      `CHECK_EQ(brakeActive, 1'b1);
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0402);
      $display("test brake done");
      wakeReq <= 1'b1;
      killReq <= 1'b1;
      waitc(8);
      `CHECK_EQ(gatesPulldown, 1'b1);
      `CHECK_EQ(sleepRequest, 1'b0);
      @(posedge clk_sys);
      killReq <= 1'b0;
      seen = 1'b0;
      repeat (12) begin
         @(posedge clk_sys);
         if (restartPulse === 1'b1) seen = 1'b1;
      end
      `CHECK_EQ(seen, 1'b1);
      wakeReq <= 1'b0;
      waitc(6);
      `CHECK_EQ(sleepRequest, 1'b1);
      $display("test kill done");
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0420);
      waitc(6);
      `CHECK_EQ(monMode, cmd_frontend_pkg::PIN_ANALOG);
      `CHECK_EQ(sleepRequest, 1'b1);
      @(posedge clk_sys);
      wakeReq <= 1'b1;
      analogLevel <= 8'h10;
      waitc(8);
      `CHECK_EQ(dutyCommand, 8'h00);
      @(posedge clk_sys);
      analogLevel <= 8'hf0;
      waitc(8);
      `CHECK_EQ(dutyCommand, cmd_frontend_pkg::FULL_DUTY);
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0401);
      waitc(300);
      `CHECK_EQ(dutyCommand, cmd_frontend_pkg::FULL_DUTY);
      wakeReq <= 1'b0;
      waitc(300);
      `CHECK_EQ(motorStop, 1'b1);
      wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0403);
      wakeToggle <= 1'b1;
      waitc(300);
      `CHECK_EQ(dutyCommand, cmd_frontend_pkg::FULL_DUTY);
      @(posedge clk_sys);
      wakeToggle <= 1'b0;
      waitc(300);
      `CHECK_EQ(dutyCommand, 8'h00);
      $display("test command sources done");
      wbAccess(1'b1, cmd_frontend_pkg::PROFILE_OFF, 32'ha020_c040);
      for (int i = 1; i < 4; i++) begin
         wbAccess(1'b1, cmd_frontend_pkg::CONFIG_OFF, 32'h0402 | (i << 2));
         waitc(6);
         `CHECK_EQ(referenceOut, (i == 1) ? 8'h60 : 8'ha0);
      end
      `CHECK_EQ(dirReverse, 1'b1);
      `CHECK_EQ(oscTrim, 16'h0008);
      $display("test profiles done");
      printVerdict();
   end
endmodule
bind motor_command_input_frontend motor_command_input_frontend_props u_props (.clk_sys(clk_sys), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .driver_kill_in(driver_kill_in),
   .gates_pulldown(gates_pulldown), .restart_pulse(restart_pulse), .brake_active(brake_active),
   .direction_reverse(direction_reverse), .phase_order(phase_order), .monitor_pin_mode(monitor_pin_mode),
   .monitor_pin_oe(monitor_pin_oe), .duty_command(duty_command), .reference_out(reference_out),
   .scaled_reference(scaled_reference), .motor_stop(motor_stop));
